// ---- src/adcsc_top.sv ----
// Top of the ADC sequence control: register port, pin functions, interrupt gate, converter
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module adcsc_top
    import adcsc_pkg::*;
(
    input wire logic sys_clk, // System clock, 10 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [2:0] reg_addr, // Register index
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic reg_rd, // Read strobe, one cycle
    output logic [7:0] reg_rdata, // Read data, valid the cycle after the read strobe
    input wire logic cmp_result, // Comparator: input at or above trial level
    input wire logic [EXT_PINS-1:0] port_pullup_req, // Pull-high enables from the port logic
    input wire logic [EXT_PINS-1:0] port_dir_out_req, // Output direction from the port logic
    output logic [3:0] channel_route, // Analog mux select
    output logic internal_source_sel, // An internal source is routed to the converter
    output logic ref_external_sel, // Reference taken from the external reference pin
    output logic ext_ref_pin_func, // External reference pin function enable
    output logic converter_power, // Converter analog power
    output logic converter_reset, // Converter held in reset
    output logic sample_hold, // Sample switch closed
    output logic [RESULT_W-1:0] dac_code, // Trial code for the comparator DAC
    output logic [EXT_PINS-1:0] pin_analog, // Pin connected as analog input
    output logic [EXT_PINS-1:0] pin_other_func_en, // Digital and shared functions of the pin
    output logic [EXT_PINS-1:0] pin_pullup, // Pull-high actually connected
    output logic [EXT_PINS-1:0] pin_drive_en_n, // Output enable, low while the pin is driven
    output logic irq_request // End-of-conversion interrupt to the processor
);

    ////////////////////////////////////////////////////////////////////////////////
    // Converter link and submodules

    adcsc_conv_if conv ();

    adcsc_clkdiv u_clkdiv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .conv(conv.divider)
    );

    adcsc_sar u_sar (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .conv(conv.sar)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register state

    logic start_reg, start_next;
    logic pending_reg, pending_next;
    logic power_reg, power_next;
    logic justify_reg, justify_next;
    logic [3:0] chan_reg, chan_next;
    logic [1:0] ref_sel_reg, ref_sel_next;
    logic [2:0] div_reg, div_next;
    logic [EXT_PINS-1:0] pin_func_a_reg, pin_func_a_next;
    logic pin_func_b_reg, pin_func_b_next;
    logic global_en_reg, global_en_next;
    logic conv_en_reg, conv_en_next;
    logic flag_reg, flag_next;
    logic launch_reg, launch_next;
    logic [7:0] rdata_reg, rdata_next;
    logic wr_ctrl_a, wr_ctrl_b, wr_pin_a, wr_pin_b, wr_irq;

    // Places the 12-bit code in the high or low byte for either justification
    function automatic logic [7:0] result_byte(input logic [RESULT_W-1:0] code, input logic right,
                                               input logic high);
        logic [15:0] placed;
        placed = right ? {4'h0, code} : {code, 4'h0};
        result_byte = high ? placed[15:8] : placed[7:0];
    endfunction

    always_comb
    begin
        wr_ctrl_a = reg_wr && (reg_addr == ADDR_CONTROL_A);
        wr_ctrl_b = reg_wr && (reg_addr == ADDR_CONTROL_B);
        wr_pin_a = reg_wr && (reg_addr == ADDR_PIN_FUNC_A);
        wr_pin_b = reg_wr && (reg_addr == ADDR_PIN_FUNC_B);
        wr_irq = reg_wr && (reg_addr == ADDR_IRQ_CTRL);

        start_next = wr_ctrl_a ? reg_wdata[CA_START_BIT] : start_reg;
        power_next = wr_ctrl_a ? reg_wdata[CA_POWER_BIT] : power_reg;
        justify_next = wr_ctrl_a ? reg_wdata[CA_JUSTIFY_BIT] : justify_reg;
        chan_next = wr_ctrl_a ? reg_wdata[3:0] : chan_reg;
        ref_sel_next = wr_ctrl_b ? reg_wdata[CB_REF_LSB+1:CB_REF_LSB] : ref_sel_reg;
        div_next = wr_ctrl_b ? reg_wdata[2:0] : div_reg;
        pin_func_a_next = wr_pin_a ? reg_wdata[EXT_PINS-1:0] : pin_func_a_reg;
        pin_func_b_next = wr_pin_b ? reg_wdata[0] : pin_func_b_reg;
        global_en_next = wr_irq ? reg_wdata[IRQ_GLOBAL_BIT] : global_en_reg;
        conv_en_next = wr_irq ? reg_wdata[IRQ_CONV_BIT] : conv_en_reg;

        // Falling start begins the conversion; a rising one aborts any running one
        launch_next = wr_ctrl_a && start_reg && !reg_wdata[CA_START_BIT];

        // Start held high forces pending; otherwise the end of conversion clears it
        if (start_next)
            pending_next = 1'b1;
        else if (conv.done)
            pending_next = 1'b0;
        else
            pending_next = pending_reg;

        // End of conversion beats a software clear in the same cycle
        if (conv.done)
            flag_next = 1'b1;
        else if (wr_irq)
            flag_next = reg_wdata[IRQ_FLAG_BIT];
        else
            flag_next = flag_reg;

        rdata_next = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_RESULT_LOW: rdata_next = result_byte(conv.result, justify_reg, 1'b0);
                ADDR_RESULT_HIGH: rdata_next = result_byte(conv.result, justify_reg, 1'b1);
                ADDR_CONTROL_A: rdata_next = {start_reg, pending_reg, power_reg, justify_reg, chan_reg};
                ADDR_CONTROL_B: rdata_next = {3'b000, ref_sel_reg, div_reg};
                ADDR_PIN_FUNC_A: rdata_next = {3'b000, pin_func_a_reg};
                ADDR_PIN_FUNC_B: rdata_next = {7'b000_0000, pin_func_b_reg};
                ADDR_IRQ_CTRL: rdata_next = {5'b0_0000, flag_reg, conv_en_reg, global_en_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_reg <= CONTROL_A_RESET[CA_START_BIT];
            pending_reg <= CONTROL_A_RESET[CA_PENDING_BIT];
            power_reg <= CONTROL_A_RESET[CA_POWER_BIT];
            justify_reg <= CONTROL_A_RESET[CA_JUSTIFY_BIT];
            chan_reg <= CONTROL_A_RESET[3:0];
            ref_sel_reg <= CONTROL_B_RESET[CB_REF_LSB+1:CB_REF_LSB];
            div_reg <= CONTROL_B_RESET[2:0];
            pin_func_a_reg <= PIN_FUNC_RESET[EXT_PINS-1:0];
            pin_func_b_reg <= PIN_FUNC_RESET[0];
            global_en_reg <= IRQ_CTRL_RESET[IRQ_GLOBAL_BIT];
            conv_en_reg <= IRQ_CTRL_RESET[IRQ_CONV_BIT];
            flag_reg <= IRQ_CTRL_RESET[IRQ_FLAG_BIT];
            launch_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            start_reg <= start_next;
            pending_reg <= pending_next;
            power_reg <= power_next;
            justify_reg <= justify_next;
            chan_reg <= chan_next;
            ref_sel_reg <= ref_sel_next;
            div_reg <= div_next;
            pin_func_a_reg <= pin_func_a_next;
            pin_func_b_reg <= pin_func_b_next;
            global_en_reg <= global_en_next;
            conv_en_reg <= conv_en_next;
            flag_reg <= flag_next;
            launch_reg <= launch_next;
            rdata_reg <= rdata_next;
        end
    end

    // The sequencer runs on its own from launch to done unless start rises again; software polls, waits or aborts
    assign conv.launch = launch_reg;
    assign conv.hold = start_reg;
    assign conv.power = power_reg;
    assign conv.div_sel = div_reg;
    assign conv.cmp = cmp_result;

    ////////////////////////////////////////////////////////////////////////////////
    // Registered pin, routing and interrupt outputs

    logic [3:0] route_reg;
    logic internal_reg, ref_ext_reg, ref_func_reg, reset_out_reg, irq_reg;
    logic [EXT_PINS-1:0] analog_reg, other_reg, pullup_reg, drive_n_reg;
    logic [3:0] route_next;
    logic internal_next, ref_ext_next, ref_func_next, reset_out_next, irq_next;
    logic [EXT_PINS-1:0] analog_next, other_next, pullup_next, drive_n_next;

    always_comb
    begin
        route_next = chan_reg;
        internal_next = (chan_reg == CH_OVERCURRENT_AMP) || (chan_reg == CH_SUPPLY_DETECT)
                        || (chan_reg == CH_BANDGAP);
        // Codes 00, 10 and 11 all fall back to the analog supply
        ref_ext_next = (ref_sel_reg == REF_EXT_PIN);
        ref_func_next = pin_func_b_reg;
        reset_out_next = start_reg;
        analog_next = pin_func_a_reg;
        other_next = ~pin_func_a_reg;
        pullup_next = port_pullup_req & ~pin_func_a_reg;
        // Port direction is ignored for analog pins, so no input setup is needed
        drive_n_next = ~port_dir_out_req | pin_func_a_reg;
        irq_next = global_en_reg && conv_en_reg && flag_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            route_reg <= CONTROL_A_RESET[3:0];
            internal_reg <= 1'b0;
            ref_ext_reg <= 1'b0;
            ref_func_reg <= 1'b0;
            reset_out_reg <= 1'b0;
            analog_reg <= '0;
            other_reg <= '1;
            pullup_reg <= '0;
            drive_n_reg <= '1;
            irq_reg <= 1'b0;
        end
        else
        begin
            route_reg <= route_next;
            internal_reg <= internal_next;
            ref_ext_reg <= ref_ext_next;
            ref_func_reg <= ref_func_next;
            reset_out_reg <= reset_out_next;
            analog_reg <= analog_next;
            other_reg <= other_next;
            pullup_reg <= pullup_next;
            drive_n_reg <= drive_n_next;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign channel_route = route_reg;
    assign internal_source_sel = internal_reg;
    assign ref_external_sel = ref_ext_reg;
    assign ext_ref_pin_func = ref_func_reg;
    assign converter_power = power_reg;
    assign converter_reset = reset_out_reg;
    assign sample_hold = conv.sampling;
    assign dac_code = conv.trial;
    assign pin_analog = analog_reg;
    assign pin_other_func_en = other_reg;
    assign pin_pullup = pullup_reg;
    assign pin_drive_en_n = drive_n_reg;
    assign irq_request = irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    // Helper counters: cycles and converter ticks since the last launch
    logic [11:0] chk_cyc_reg;
    logic [4:0] chk_ticks_reg;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_cyc_reg <= 12'h000;
            chk_ticks_reg <= 5'h00;
        end
        else
        begin
            if (launch_reg)
                chk_cyc_reg <= 12'h001;
            else if (chk_cyc_reg != 12'hFFF)
                chk_cyc_reg <= chk_cyc_reg + 12'h001;
            if (launch_reg)
                chk_ticks_reg <= 5'h00;
            else if (conv.tick && chk_ticks_reg != 5'h1F)
                chk_ticks_reg <= chk_ticks_reg + 5'h01;
        end
    end

    a_start_forces_pending: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start_reg |-> pending_reg && !conv.done ##1 converter_reset)
        else $error("pending not forced or converter not held while start is high");

    a_done_clears_pending: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv.done && !start_next |=> !pending_reg
        && conv.result == {$past(conv.trial[RESULT_W-1:1]), $past(conv.cmp)})
        else $error("pending flag or stored result wrong after end of conversion");

    a_conv_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv.done && $stable(div_reg) |-> chk_cyc_reg == (12'h010 << div_reg))
        else $error("conversion length is not sixteen converter clocks");

    a_phase_split: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(conv.sampling) && !conv.hold |-> chk_ticks_reg == {1'b0, SAMPLE_CLKS})
        and (conv.done |-> chk_ticks_reg == TOTAL_CLKS - 5'h01))
        else $error("sampling or conversion phase has the wrong length");

    a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_request |-> $past(global_en_reg && conv_en_reg && flag_reg))
        else $error("interrupt raised without both enables and the flag");

    a_flag_on_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv.done |=> flag_reg ##1 (irq_request == (global_en_reg && conv_en_reg) || $past(wr_irq)))
        else $error("end of conversion lost or interrupt gate wrong");

    a_pullup_cut: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 (pin_pullup == ($past(port_pullup_req) & ~$past(pin_func_a_reg))) && ((pin_pullup & pin_analog) == '0))
        else $error("pull-high left on an analog pin");

    a_dir_override: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((~pin_drive_en_n & pin_analog) == '0) && ((pin_other_func_en & pin_analog) == '0))
        else $error("analog pin still driven or shared function still on");

    a_abort_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(conv.result) |-> $past(conv.done))
        else $error("result changed without a finished conversion");

    a_justify_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_addr == ADDR_RESULT_LOW && !justify_reg |=> reg_rdata[3:0] == 4'h0)
        else $error("unused low result bits not zero");

    a_ref_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(ref_sel_reg) |=> ref_external_sel == ($past(ref_sel_reg) == REF_EXT_PIN))
        else $error("reference routing does not follow the select field");

    a_power_no_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !power_reg |-> !conv.tick && !conv.done)
        else $error("converter clock ran while powered down");

    // Launch, hold and busy relations, and the unused high result bits
    a_launch_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        launch_reg |-> $past(start_reg) && !start_reg)
        else $error("conversion launched without start falling");

    a_launch_samples: assert property (@(posedge sys_clk) disable iff (!rst_n)
        launch_reg |=> sample_hold)
        else $error("sampling did not open after launch");

    a_hold_idles: assert property (@(posedge sys_clk) disable iff (!rst_n)
        converter_reset |-> !sample_hold && dac_code == '0)
        else $error("sequencer not idle while converter held in reset");

    a_pending_while_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sample_hold || dac_code != '0 |-> pending_reg)
        else $error("pending flag low while a conversion is running");

    a_justify_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_addr == ADDR_RESULT_HIGH && justify_reg |=> reg_rdata[7:4] == 4'h0)
        else $error("unused high result bits not zero");

endmodule // adcsc_top
`default_nettype wire

// ---- pkg/adcsc_pkg.sv ----
// Package: register map, field layout, timing counts and types of the ADC sequence control
`default_nettype none
package adcsc_pkg;
    localparam int unsigned RESULT_W = 12;
    localparam int unsigned EXT_PINS = 5;
    // Register indexes on the 3-bit register port
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h0;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
    localparam logic [2:0] ADDR_CONTROL_A = 3'h2;
    localparam logic [2:0] ADDR_CONTROL_B = 3'h3;
    localparam logic [2:0] ADDR_PIN_FUNC_A = 3'h4;
    localparam logic [2:0] ADDR_PIN_FUNC_B = 3'h5;
    localparam logic [2:0] ADDR_IRQ_CTRL = 3'h6;
    // Field positions
    localparam int unsigned CA_START_BIT = 7;
    localparam int unsigned CA_PENDING_BIT = 6;
    localparam int unsigned CA_POWER_BIT = 5;
    localparam int unsigned CA_JUSTIFY_BIT = 4;
    localparam int unsigned CB_REF_LSB = 3;
    localparam int unsigned IRQ_GLOBAL_BIT = 0;
    localparam int unsigned IRQ_CONV_BIT = 1;
    localparam int unsigned IRQ_FLAG_BIT = 2;
    // Values after reset
    localparam logic [7:0] CONTROL_A_RESET = 8'h40;
    localparam logic [7:0] CONTROL_B_RESET = 8'h00;
    localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
    // Converter clock counts and the first trial code
    localparam logic [3:0] SAMPLE_CLKS = 4'h4;
    localparam logic [3:0] CONV_CLKS = 4'hC;
    localparam logic [4:0] TOTAL_CLKS = 5'h10;
    localparam logic [RESULT_W-1:0] RESULT_MSB = 12'h800;
    // Codes
    localparam logic [1:0] REF_EXT_PIN = 2'h1;
    localparam logic [3:0] CH_OVERCURRENT_AMP = 4'h0;
    localparam logic [3:0] CH_SUPPLY_DETECT = 4'h5;
    localparam logic [3:0] CH_BANDGAP = 4'h8;
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} adcsc_phase_t;
endpackage
`default_nettype wire

// ---- pkg/adcsc_conv_if.sv ----
// Interface: link between register front end, converter clock divider and SAR sequencer
`timescale 1ns/100ps
`default_nettype none
interface adcsc_conv_if;
    import adcsc_pkg::*;
    logic launch;
    logic hold;
    logic power;
    logic [2:0] div_sel;
    logic tick;
    logic cmp;
    logic done;
    logic sampling;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] trial;
    modport ctrl (output launch, hold, power, div_sel, cmp, input tick, done, sampling, result, trial);
    modport divider (input launch, power, div_sel, output tick);
    modport sar (input launch, hold, tick, cmp, output done, sampling, result, trial);
endinterface
`default_nettype wire

// ---- src/adcsc_clkdiv.sv ----
// Converter clock divider: one tick every two-to-the-field system clocks
`timescale 1ns/100ps
`default_nettype none
module adcsc_clkdiv
    import adcsc_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    adcsc_conv_if.divider conv // Divider side of the converter link
);
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic [6:0] limit;
    always_comb
    begin
        limit = 7'((8'h01 << conv.div_sel) - 8'h01);
        // No tick while powered down, and restart phase-aligned to each launch
        conv.tick = conv.power && !conv.launch && (cnt_reg >= limit);
        if (!conv.power || conv.launch || conv.tick)
            cnt_next = 7'h00;
        else
            cnt_next = cnt_reg + 7'h01;
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= 7'h00;
        else
            cnt_reg <= cnt_next;
    end
endmodule // adcsc_clkdiv
`default_nettype wire

// ---- src/adcsc_sar.sv ----
// SAR sequencer: sampling phase, bit-by-bit approximation and result register
`timescale 1ns/100ps
`default_nettype none
module adcsc_sar
    import adcsc_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    adcsc_conv_if.sar conv // Sequencer side of the converter link
);
    adcsc_phase_t phase_reg, phase_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [RESULT_W-1:0] trial_reg, trial_next, result_reg, result_next, mask, kept;
    logic sample_reg, sample_next;
    always_comb
    begin
        phase_next = phase_reg;
        cnt_next = cnt_reg;
        trial_next = trial_reg;
        result_next = result_reg;
        conv.done = 1'b0;
        mask = RESULT_MSB >> cnt_reg;
        kept = conv.cmp ? trial_reg : (trial_reg & ~mask);
        if (conv.hold || conv.launch)
        begin
            // Held in reset while start is high; launch opens sampling
            phase_next = conv.hold ? SAR_IDLE : SAR_SAMPLE;
            cnt_next = 4'h0;
            trial_next = '0;
        end
        else if (conv.tick)
        begin
            unique case (phase_reg)
                SAR_IDLE:
                begin
                    cnt_next = 4'h0;
                end
                SAR_SAMPLE:
                begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == SAMPLE_CLKS - 4'h1)
                    begin
                        phase_next = SAR_CONVERT;
                        cnt_next = 4'h0;
                        trial_next = RESULT_MSB;
                    end
                end
                SAR_CONVERT:
                begin
                    cnt_next = cnt_reg + 4'h1;
                    trial_next = kept | (mask >> 1);
                    if (cnt_reg == CONV_CLKS - 4'h1)
                    begin
                        conv.done = 1'b1;
                        result_next = kept;
                        phase_next = SAR_IDLE;
                        cnt_next = 4'h0;
                        trial_next = '0;
                    end
                end
            endcase
        end
        sample_next = (phase_next == SAR_SAMPLE);
    end
    assign conv.result = result_reg;
    assign conv.trial = trial_reg;
    assign conv.sampling = sample_reg;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= SAR_IDLE;
            cnt_reg <= 4'h0;
            trial_reg <= '0;
            result_reg <= '0;
            sample_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            trial_reg <= trial_next;
            result_reg <= result_next;
            sample_reg <= sample_next;
        end
    end
endmodule // adcsc_sar
`default_nettype wire

// ---- test/adcsc_tb.sv ----
// Self-checking bench for the ADC sequence control top
`timescale 1ns/100ps
`default_nettype none
module adcsc_tb;
    import adcsc_pkg::*;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cmp_result;
    logic [2:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [4:0] port_pullup_req = 0, port_dir_out_req = 0, fa, pin_analog, pin_other_func_en, pin_pullup, pin_drive_en_n;
    logic [11:0] vin = 0, dac_code;
    logic [3:0] channel_route;
    logic internal_source_sel, ref_external_sel, ext_ref_pin_func, converter_power, converter_reset;
    logic sample_hold, irq_request;
    int error_cnt = 0, compares = 0;
    integer seed = 32'h0000_37c1;
    // Ideal comparator: keeps a trial bit while the input is at or above it
    assign cmp_result = (dac_code <= vin);
    always #50 sys_clk = ~sys_clk;
    adcsc_top dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_result,
        .port_pullup_req, .port_dir_out_req, .channel_route, .internal_source_sel, .ref_external_sel,
        .ext_ref_pin_func, .converter_power, .converter_reset, .sample_hold, .dac_code, .pin_analog,
        .pin_other_func_en, .pin_pullup, .pin_drive_en_n, .irq_request);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    function automatic logic [7:0] res_byte(input logic [11:0] v, input logic j, input logic hi);
        logic [15:0] w;
        w = j ? {4'h0, v} : {v, 4'h0};
        return hi ? w[15:8] : w[7:0];
    endfunction
    // Pending must still be set one read before the 16-clock mark and clear right after
    task automatic conv(input logic [2:0] div, input logic j);
        wr(ADDR_CONTROL_B, {5'h00, div});
        wr(ADDR_CONTROL_A, {3'b101, j, 4'h1});
        @(posedge sys_clk);
        #1 chk(converter_reset, 1'b1);
        wr(ADDR_CONTROL_A, {3'b001, j, 4'h1});
        repeat (4 * 2 ** div) @(posedge sys_clk);
        #1 chk(sample_hold, 1'b1);
        @(posedge sys_clk);
        #1 chk(sample_hold, 1'b0);
        chk(dac_code, 12'h800);
        repeat (12 * 2 ** div - 3) @(posedge sys_clk);
        rc(ADDR_CONTROL_A, {3'b011, j, 4'h1});
        rc(ADDR_CONTROL_A, {3'b001, j, 4'h1});
    endtask
    task automatic final_report;
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rc(ADDR_CONTROL_A, 8'h40);
        rc(3'h7, 8'h00);
        wr(ADDR_PIN_FUNC_B, 8'h01);
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_CONTROL_A, {4'h2, i[3:0]});
            wr(ADDR_CONTROL_B, {3'h0, i[1:0], 3'h0});
            @(posedge sys_clk);
            #1 chk(channel_route, i[3:0]);
            chk(internal_source_sel, i == 0 || i == 5 || i == 8);
            chk(ref_external_sel, i[1:0] == 2'h1);
        end
        repeat (4)
        begin
            @(posedge sys_clk);
            fa = 5'($random(seed));
            port_pullup_req <= 5'($random(seed));
            port_dir_out_req <= 5'($random(seed));
            wr(ADDR_PIN_FUNC_A, {3'h0, fa});
            wr(ADDR_PIN_FUNC_B, {7'h00, fa[0]});
            @(posedge sys_clk);
            #1 chk(pin_other_func_en, 5'(~fa));
            chk(pin_analog, fa);
            chk(pin_pullup, 5'(port_pullup_req & ~fa));
            chk(pin_drive_en_n, 5'(~port_dir_out_req | fa));
            chk(ext_ref_pin_func, fa[0]);
        end
        for (int k = 0; k < 8; k++)
        begin
            wr(ADDR_IRQ_CTRL, {5'h00, k[2:0]});
            @(posedge sys_clk);
            #1 chk(irq_request, k == 7);
        end
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_IRQ_CTRL, 8'h03);
            vin <= (i < 2) ? {12{~i[0]}} : 12'($random(seed));
            conv((i == 4) ? 3'h7 : i[2:0], i[0]);
            rc(ADDR_RESULT_HIGH, res_byte(vin, i[0], 1'b1));
            rc(ADDR_RESULT_LOW, res_byte(vin, i[0], 1'b0));
            rc(ADDR_IRQ_CTRL, 8'h07);
            chk(irq_request, 1'b1);
        end
        // Abort mid-conversion with a new input: the stored result must not move
        vin <= ~vin;
        wr(ADDR_CONTROL_B, 8'h02);
        wr(ADDR_CONTROL_A, 8'hA1);
        wr(ADDR_CONTROL_A, 8'h21);
        repeat (30) @(posedge sys_clk);
        wr(ADDR_CONTROL_A, 8'hA1);
        rc(ADDR_CONTROL_A, 8'hE1);
        rc(ADDR_RESULT_HIGH, res_byte(~vin, 1'b0, 1'b1));
        wr(ADDR_CONTROL_A, 8'h21);
        repeat (66) @(posedge sys_clk);
        rc(ADDR_RESULT_HIGH, res_byte(vin, 1'b0, 1'b1));
        wr(ADDR_CONTROL_A, 8'h81);
        wr(ADDR_CONTROL_A, 8'h01);
        repeat (40) @(posedge sys_clk);
        rc(ADDR_CONTROL_A, 8'h41);
        chk(converter_power, 1'b0);
        final_report();
    end
endmodule // adcsc_tb
`default_nettype wire
